/* logic/osc_switch_tune_ctrl.sv */
// Oscillator switch, fail-safe, PLL lock and RC trim control with bus slave
`timescale 1ns/10ps
`default_nettype none

// What this block does
// R1 - Active group is read-only at bits 14:12; codes 100-111 reserved.
// R2 - Power-on reset forces the active group to internal RC.
// R3 - Successful switch copies the requested group into the active group.
// R4 - Fail-safe monitor failure forces the active group to internal RC.
// R5 - Requested group writable at bits 10:8, reset value from config.
// R6 - Lock bit plus upper monitor config bit block clock and PLL changes.
// R7 - Lock bit, once set, is cleared only by reset.
// R8 - PLL lock status at bit 5, read only, cleared on reset.
// R9 - PLL lock cleared on switch start or lock loss, set on lock.
// R10 - PLL lock reads zero when PLL is not in the active clock.
// R11 - Bit 4 enables pseudo-random clock dither, reset to zero.
// R12 - Fail flag at bit 3: set on failure, cleared by software or switch.
// R13 - Sequencer off trims from base field; on selects by PWM phase.
// R14 - Phases 001-011 pick sequence trims one to three from low tune register.
// R15 - Trim codes are signed four-bit: 0000 centre, 0111 max, 1000 min.
// R16 - Software sets switch request at bit 0; hardware clears it when done.
// R17 - Switch request set on reset unless configured group is internal RC; clears on success, redundant switch, fallback.
// R18 - Reset source from configuration; later only permitted groups.
// R19 - Bits 15, 11, 6 and 1 ignore writes and read zero.
// R20 - Phases 100-111 pick sequence trims four to seven, high register.
// R21 - Low byte needs 46h,57h key; high byte 78h,9Ah; one write each.
// R22 - Request for a reserved group code is a no-op that clears the request.
module osc_switch_tune_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Configuration straps, static after power-up
  input wire osc_ctrl_pkg::cfg_s cfg,
  // Oscillator status from the analog side
  input wire logic osc_ready,
  input wire logic pll_locked,
  input wire logic clock_fail,
  // PWM phase selector, same clock domain
  input wire logic [2:0] pwm_phase,
  // Oscillator controls
  output logic [2:0] active_clock_group,
  output logic [2:0] switch_target,
  output logic switch_busy,
  output logic clock_dither_enable,
  output logic [3:0] rc_trim
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic uses_pll(input logic [2:0] grp);
    uses_pll = (grp == osc_ctrl_pkg::grp_frc_pll) ||
               (grp == osc_ctrl_pkg::grp_pri_pll);
  endfunction : uses_pll

  // Signed trim code passes unchanged; the RC decodes it as two's complement
  function automatic logic [3:0] trim_pick(input logic [2:0] phase,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi,
                                           input logic seq_en);
    if (!seq_en || phase == 3'h0) begin
      trim_pick = lo[3:0]; // R13 R15
    end else if (!phase[2]) begin
      trim_pick = lo[4*phase[1:0] +: 4]; // R14
    end else begin
      trim_pick = hi[4*phase[1:0] +: 4]; // R20
    end
  endfunction : trim_pick

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [2:0] sync1_r;
  logic [2:0] sync2_r;
  logic fail_prev_r;
  logic ready_s;
  logic locked_s;
  logic fail_s;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync1_r <= 3'h0;
      sync2_r <= 3'h0;
      fail_prev_r <= 1'b0;
    end else begin
      sync1_r <= {clock_fail, pll_locked, osc_ready};
      sync2_r <= sync1_r;
      fail_prev_r <= sync2_r[2];
    end
  end

  assign ready_s = sync2_r[0];
  assign locked_s = sync2_r[1];
  assign fail_s = sync2_r[2];

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  logic req;
  logic accept;
  logic wr_accept;
  logic wr_ctrl;

  assign req = avs_read || avs_write;
  assign accept = req && !avs_waitrequest;
  assign wr_accept = avs_write && !avs_waitrequest;
  assign wr_ctrl = wr_accept && avs_address == osc_ctrl_pkg::addr_ctrl;

  // Waitrequest drops one cycle after the request, for exactly one cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (accept) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !req;
    end
  end

  // ****************************************************************
  // Write unlock sequencers
  // ****************************************************************
  osc_ctrl_pkg::key_state_e key_lo_r;
  osc_ctrl_pkg::key_state_e key_hi_r;
  logic lo_write;
  logic hi_write;

  // Any other access in between breaks the sequence
  assign lo_write = wr_ctrl && avs_byteenable[0] &&
                    key_lo_r == osc_ctrl_pkg::key_armed; // R21
  assign hi_write = wr_ctrl && avs_byteenable[1] &&
                    key_hi_r == osc_ctrl_pkg::key_armed; // R21

  function automatic osc_ctrl_pkg::key_state_e key_step(
      input osc_ctrl_pkg::key_state_e st, input logic lane_wr,
      input logic [7:0] data, input logic [7:0] k1, input logic [7:0] k2);
    if (!lane_wr || st == osc_ctrl_pkg::key_armed) begin
      key_step = osc_ctrl_pkg::key_idle;
    end else if (st == osc_ctrl_pkg::key_half && data == k2) begin
      key_step = osc_ctrl_pkg::key_armed;
    end else if (data == k1) begin
      key_step = osc_ctrl_pkg::key_half;
    end else begin
      key_step = osc_ctrl_pkg::key_idle;
    end
  endfunction : key_step

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      key_lo_r <= osc_ctrl_pkg::key_idle;
      key_hi_r <= osc_ctrl_pkg::key_idle;
    end else if (accept) begin
      key_lo_r <= key_step(key_lo_r, wr_ctrl && avs_byteenable[0],
                           avs_writedata[7:0], osc_ctrl_pkg::key_lo_first,
                           osc_ctrl_pkg::key_lo_second); // R21
      key_hi_r <= key_step(key_hi_r, wr_ctrl && avs_byteenable[1],
                           avs_writedata[15:8], osc_ctrl_pkg::key_hi_first,
                           osc_ctrl_pkg::key_hi_second); // R21
    end
  end

  // ****************************************************************
  // Control fields
  // ****************************************************************
  logic [2:0] requested_clock_group_r;
  logic clock_config_lock_r;
  logic trim_sequencer_enable_r;
  logic clock_fail_flag_r;
  logic switch_request_r;
  logic pll_lock_r;
  logic blocked;
  logic fail_event;
  osc_ctrl_pkg::sw_state_e sw_state_r;

  assign blocked = clock_config_lock_r &&
                   cfg.switch_monitor_cfg[1]; // R6
  // Monitor only acts when both monitor config bits are clear
  assign fail_event = fail_s && !fail_prev_r &&
                      cfg.switch_monitor_cfg == 2'h0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      requested_clock_group_r <= {1'b0, cfg.initial_group}; // R5 R18
    end else if (hi_write && !blocked) begin
      requested_clock_group_r <=
          avs_writedata[osc_ctrl_pkg::requested_lsb +: 3]; // R5 R6
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clock_config_lock_r <= 1'b0; // R7
    end else if (lo_write && avs_writedata[osc_ctrl_pkg::lock_cfg_bit]) begin
      clock_config_lock_r <= 1'b1; // R7
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clock_dither_enable <= 1'b0; // R11
      trim_sequencer_enable_r <= 1'b0;
    end else if (lo_write) begin
      clock_dither_enable <= avs_writedata[osc_ctrl_pkg::dither_bit]; // R11
      trim_sequencer_enable_r <= avs_writedata[osc_ctrl_pkg::tseq_bit];
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clock_fail_flag_r <= 1'b0; // R12
    end else if (fail_event) begin
      clock_fail_flag_r <= 1'b1; // R12
    end else if (sw_state_r == osc_ctrl_pkg::sw_idle && start_ok) begin
      // Redundant or reserved requests are no switch start
      clock_fail_flag_r <= 1'b0; // R12
    end else if (lo_write && !avs_writedata[osc_ctrl_pkg::fail_bit]) begin
      clock_fail_flag_r <= 1'b0; // R12
    end
  end

  // ****************************************************************
  // Clock switch state machine
  // ****************************************************************
  logic start_ok;
  logic target_ready;

  // Reserved codes and a switch to the running group never start
  assign start_ok = switch_request_r && !blocked && !fail_event &&
                    !requested_clock_group_r[2] &&
                    requested_clock_group_r != active_clock_group; // R18 R22
  assign target_ready = ready_s &&
                        (!uses_pll(switch_target) || locked_s);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sw_state_r <= osc_ctrl_pkg::sw_idle;
      switch_target <= osc_ctrl_pkg::grp_frc;
    end else if (fail_event) begin
      sw_state_r <= osc_ctrl_pkg::sw_idle;
      switch_target <= osc_ctrl_pkg::grp_frc;
    end else begin
      unique case (sw_state_r)
        osc_ctrl_pkg::sw_idle: begin
          if (start_ok) begin
            sw_state_r <= osc_ctrl_pkg::sw_wait;
            switch_target <= requested_clock_group_r;
          end
        end
        osc_ctrl_pkg::sw_wait: begin
          if (target_ready) begin
            sw_state_r <= osc_ctrl_pkg::sw_idle;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      switch_busy <= 1'b0;
    end else begin
      switch_busy <= (sw_state_r == osc_ctrl_pkg::sw_idle) ? start_ok :
                     !(target_ready || fail_event);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_clock_group <= osc_ctrl_pkg::grp_frc; // R2
    end else if (fail_event) begin
      active_clock_group <= osc_ctrl_pkg::grp_frc; // R4
    end else if (sw_state_r == osc_ctrl_pkg::sw_wait && target_ready) begin
      active_clock_group <= switch_target; // R3
    end
  end

  // Reset raises a request when the configured group is not internal RC
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      switch_request_r <= cfg.initial_group != 2'h0; // R17 R18
    end else if (fail_event) begin
      switch_request_r <= 1'b0; // R17
    end else if (sw_state_r == osc_ctrl_pkg::sw_wait && target_ready) begin
      switch_request_r <= 1'b0; // R16 R17
    end else if (sw_state_r == osc_ctrl_pkg::sw_idle && switch_request_r &&
                 !blocked && !start_ok) begin
      switch_request_r <= 1'b0; // R17 R22
    end else if (lo_write && !blocked &&
                 avs_writedata[osc_ctrl_pkg::swreq_bit]) begin
      switch_request_r <= 1'b1; // R16
    end
  end

  // ****************************************************************
  // PLL lock status
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pll_lock_r <= 1'b0; // R8
    end else if (sw_state_r == osc_ctrl_pkg::sw_idle && start_ok) begin
      pll_lock_r <= 1'b0; // R9
    end else begin
      pll_lock_r <= locked_s; // R9
    end
  end

  // ****************************************************************
  // Trim output
  // ****************************************************************
  logic [15:0] tune_lo_r;
  logic [15:0] tune_hi_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tune_lo_r <= osc_ctrl_pkg::tune_reset;
      tune_hi_r <= osc_ctrl_pkg::tune_reset;
    end else if (wr_accept) begin
      for (int b = 0; b < 2; b++) begin
        if (avs_byteenable[b] &&
            avs_address == osc_ctrl_pkg::addr_tune_lo) begin
          tune_lo_r[8*b +: 8] <= avs_writedata[8*b +: 8];
        end
        if (avs_byteenable[b] &&
            avs_address == osc_ctrl_pkg::addr_tune_hi) begin
          tune_hi_r[8*b +: 8] <= avs_writedata[8*b +: 8];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rc_trim <= 4'h0;
    end else begin
      rc_trim <= trim_pick(pwm_phase, tune_lo_r, tune_hi_r,
                           trim_sequencer_enable_r); // R13 R14 R20
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  logic [15:0] ctrl_word;

  always_comb begin
    ctrl_word = 16'h0000; // R19
    ctrl_word[osc_ctrl_pkg::active_lsb +: 3] = active_clock_group; // R1
    ctrl_word[osc_ctrl_pkg::requested_lsb +: 3] = requested_clock_group_r;
    ctrl_word[osc_ctrl_pkg::lock_cfg_bit] = clock_config_lock_r;
    ctrl_word[osc_ctrl_pkg::pll_lock_bit] = pll_lock_r &&
        uses_pll(active_clock_group); // R8 R10
    ctrl_word[osc_ctrl_pkg::dither_bit] = clock_dither_enable;
    ctrl_word[osc_ctrl_pkg::fail_bit] = clock_fail_flag_r;
    ctrl_word[osc_ctrl_pkg::tseq_bit] = trim_sequencer_enable_r;
    ctrl_word[osc_ctrl_pkg::swreq_bit] = switch_request_r;
  end

  // Unmapped addresses read zero and ignore writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        osc_ctrl_pkg::addr_ctrl: avs_readdata <= {16'h0000, ctrl_word};
        osc_ctrl_pkg::addr_tune_lo: avs_readdata <= {16'h0000, tune_lo_r};
        osc_ctrl_pkg::addr_tune_hi: avs_readdata <= {16'h0000, tune_hi_r};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule : osc_switch_tune_ctrl

`default_nettype wire

/* logic/osc_ctrl_pkg.sv */
// Constants and carrier types for the oscillator switch and tune control
package osc_ctrl_pkg;

  // ****************************************************************
  // Register map (word offsets on the bus)
  // ****************************************************************
  localparam logic [3:0] addr_ctrl = 4'h0;
  localparam logic [3:0] addr_tune_lo = 4'h1;
  localparam logic [3:0] addr_tune_hi = 4'h2;

  // ****************************************************************
  // Control register field positions
  // ****************************************************************
  localparam int active_lsb = 12;
  localparam int requested_lsb = 8;
  localparam int lock_cfg_bit = 7;
  localparam int pll_lock_bit = 5;
  localparam int dither_bit = 4;
  localparam int fail_bit = 3;
  localparam int tseq_bit = 2;
  localparam int swreq_bit = 0;

  // ****************************************************************
  // Clock groups and reset values
  // ****************************************************************
  localparam logic [2:0] grp_frc = 3'h0;
  localparam logic [2:0] grp_frc_pll = 3'h1;
  localparam logic [2:0] grp_pri = 3'h2;
  localparam logic [2:0] grp_pri_pll = 3'h3;
  localparam logic [15:0] tune_reset = 16'h0000;

  // ****************************************************************
  // Write unlock key bytes
  // ****************************************************************
  localparam logic [7:0] key_lo_first = 8'h46;
  localparam logic [7:0] key_lo_second = 8'h57;
  localparam logic [7:0] key_hi_first = 8'h78;
  localparam logic [7:0] key_hi_second = 8'h9a;

  typedef enum logic [1:0] {
    key_idle,
    key_half,
    key_armed
  } key_state_e;

  typedef enum logic [0:0] {
    sw_idle,
    sw_wait
  } sw_state_e;

  // Nonvolatile configuration straps
  typedef struct packed {
    logic [1:0] switch_monitor_cfg;
    logic [1:0] initial_group;
  } cfg_s;

endpackage : osc_ctrl_pkg

/* bench/osc_ctrl_chk.sv */
// Port-level assertions for the oscillator switch and tune control
`timescale 1ns/10ps
`default_nettype none
module osc_ctrl_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Bus
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Straps and status
  input wire osc_ctrl_pkg::cfg_s cfg,
  input wire logic osc_ready,
  input wire logic pll_locked,
  input wire logic clock_fail,
  input wire logic [2:0] pwm_phase,
  // Oscillator controls
  input wire logic [2:0] active_clock_group,
  input wire logic [2:0] switch_target,
  input wire logic switch_busy,
  input wire logic clock_dither_enable,
  input wire logic [3:0] rc_trim
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic ctrl_rd;
  assign ctrl_rd = avs_read && !avs_waitrequest && avs_address == 4'h0;
  // ****************************************************************
  // Assertions
  // ****************************************************************
  grp_legal_a: assert property (!active_clock_group[2])
    else $error("active group shows a reserved code");
  rd_active_a: assert property (
    ctrl_rd |-> avs_readdata[14:12] == $past(active_clock_group))
    else $error("control read shows wrong active group");
  rst_frc_a: assert property (
    $fell(rst) |-> active_clock_group == 3'h0 && !switch_busy)
    else $error("active group not internal RC after reset");
  sw_done_a: assert property (
    $fell(switch_busy) |-> active_clock_group == $past(switch_target)
      || active_clock_group == 3'h0)
    else $error("switch ended without taking its target");
  fail_frc_a: assert property (
    $rose(clock_fail) && cfg.switch_monitor_cfg == 2'h0
      |-> ##[1:4] (active_clock_group == 3'h0 && !switch_busy))
    else $error("clock failure did not fall back to internal RC");
  busy_tgt_a: assert property (
    switch_busy |-> switch_target != active_clock_group && !switch_target[2])
    else $error("busy on a redundant or reserved target");
  dith_wr_a: assert property (
    $changed(clock_dither_enable) |-> $past(avs_write)
      && !$past(avs_waitrequest) && $past(avs_address) == 4'h0)
    else $error("dither enable moved without a control write");
  trim_src_a: assert property (
    $changed(rc_trim) |-> $past(pwm_phase) != $past(pwm_phase, 2)
      || ($past(avs_write, 2) && !$past(avs_waitrequest, 2)))
    else $error("trim moved without phase or register change");
  unimpl_a: assert property (
    ctrl_rd |-> (avs_readdata & 32'hffff8842) == 32'h0)
    else $error("unimplemented control bits read nonzero");
  pll_bit_a: assert property (
    ctrl_rd |-> !avs_readdata[5] || $past(active_clock_group[0]))
    else $error("PLL lock shown while PLL not in use");
  switch_c: cover property ($fell(switch_busy));
  fail_c: cover property ($rose(clock_fail));
  read_c: cover property (ctrl_rd);
endmodule : osc_ctrl_chk
`default_nettype wire

/* bench/osc_switch_tune_ctrl_test.sv */
// Self-checking bench for the oscillator switch and tune control
`timescale 1ns/10ps
`default_nettype none
module osc_switch_tune_ctrl_test;
  logic sys_clk;
  logic rst;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  osc_ctrl_pkg::cfg_s cfg;
  logic osc_ready;
  logic pll_locked;
  logic clock_fail;
  logic [2:0] pwm_phase;
  logic [2:0] active_clock_group;
  logic [2:0] switch_target;
  logic switch_busy;
  logic clock_dither_enable;
  logic [3:0] rc_trim;
  int errors;
  int tests_run;
  int cycles;
  logic [31:0] rd;
  osc_switch_tune_ctrl DUT (.sys_clk(sys_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cfg(cfg), .osc_ready(osc_ready), .pll_locked(pll_locked),
    .clock_fail(clock_fail), .pwm_phase(pwm_phase),
    .active_clock_group(active_clock_group), .switch_target(switch_target),
    .switch_busy(switch_busy), .clock_dither_enable(clock_dither_enable),
    .rc_trim(rc_trim));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Ceiling well above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      errors++;
      stop_test();
    end
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  // Unlock pair then the real byte, all on one lane
  task automatic key_wr(input logic hi, input logic [7:0] v);
    logic [3:0] be;
    be = hi ? 4'h2 : 4'h1;
    bus(1'b1, 4'h0, hi ? 32'h7800 : 32'h46, be);
    bus(1'b1, 4'h0, hi ? 32'h9a00 : 32'h57, be);
    bus(1'b1, 4'h0, hi ? {16'h0, v, 8'h0} : {24'h0, v}, be);
  endtask : key_wr
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hf);
    check(rd, exp);
  endtask : rd_chk
  task automatic wait_idle();
    repeat (3) @(negedge sys_clk);
    for (int i = 0; i < 20 && switch_busy !== 1'b0; i++) @(negedge sys_clk);
  endtask : wait_idle
  task automatic do_reset(input logic [3:0] c);
    cfg <= c;
    rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
  endtask : do_reset
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd_chk(4'h0, 32'h0);
    rd_chk(4'h1, 32'h0);
    rd_chk(4'h2, 32'h0);
    bus(1'b1, 4'h3, 32'h1234, 4'h3);
    rd_chk(4'h3, 32'h0);
  endtask : t_reset
  task automatic t_switch();
    key_wr(1'b1, 8'h02);
    rd_chk(4'h0, 32'h0200);
    key_wr(1'b0, 8'h01);
    repeat (3) @(negedge sys_clk);
    check({29'h0, switch_target}, 32'h2);
    rd_chk(4'h0, 32'h0201);
    osc_ready <= 1'b1;
    wait_idle();
    check({29'h0, active_clock_group}, 32'h2);
    rd_chk(4'h0, 32'h2200);
    key_wr(1'b0, 8'h01);
    rd_chk(4'h0, 32'h2200);
    key_wr(1'b1, 8'h04);
    key_wr(1'b0, 8'h01);
    rd_chk(4'h0, 32'h2400);
  endtask : t_switch
  task automatic t_pll();
    pll_locked <= 1'b1;
    key_wr(1'b1, 8'h03);
    key_wr(1'b0, 8'h01);
    wait_idle();
    rd_chk(4'h0, 32'h3320);
    pll_locked <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd_chk(4'h0, 32'h3300);
    pll_locked <= 1'b1;
    key_wr(1'b1, 8'h02);
    key_wr(1'b0, 8'h01);
    wait_idle();
    rd_chk(4'h0, 32'h2200);
  endtask : t_pll
  task automatic t_fail();
    clock_fail <= 1'b1;
    repeat (4) @(negedge sys_clk);
    check({29'h0, active_clock_group}, 32'h0);
    rd_chk(4'h0, 32'h0208);
    clock_fail <= 1'b0;
    key_wr(1'b0, 8'h00);
    rd_chk(4'h0, 32'h0200);
  endtask : t_fail
  task automatic t_bits();
    key_wr(1'b0, 8'h52);
    @(negedge sys_clk);
    check({31'h0, clock_dither_enable}, 32'h1);
    rd_chk(4'h0, 32'h0210);
    key_wr(1'b1, 8'hff);
    rd_chk(4'h0, 32'h0710);
    key_wr(1'b0, 8'h00);
  endtask : t_bits
  task automatic t_trim();
    logic [3:0] exp_t [8] = '{4'h1, 4'h7, 4'hf, 4'h8, 4'h9, 4'ha, 4'h0, 4'hc};
    bus(1'b1, 4'h1, 32'h8f71, 4'h3);
    bus(1'b1, 4'h2, 32'hc0a9, 4'h3);
    rd_chk(4'h1, 32'h8f71);
    rd_chk(4'h2, 32'hc0a9);
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < 8; p++) begin
        @(posedge sys_clk);
        pwm_phase <= 3'(p);
        repeat (3) @(negedge sys_clk);
        check({28'h0, rc_trim}, s ? {28'h0, exp_t[p]} : 32'h1);
      end
      key_wr(1'b0, 8'h04);
    end
  endtask : t_trim
  task automatic t_lock();
    do_reset(4'ha);
    wait_idle();
    rd_chk(4'h0, 32'h2200);
    key_wr(1'b0, 8'h80);
    key_wr(1'b0, 8'h00);
    rd_chk(4'h0, 32'h2280);
    key_wr(1'b1, 8'h00);
    key_wr(1'b0, 8'h81);
    repeat (3) @(negedge sys_clk);
    check({31'h0, switch_busy}, 32'h0);
    rd_chk(4'h0, 32'h2280);
    do_reset(4'h0);
    rd_chk(4'h0, 32'h0);
  endtask : t_lock
  initial begin
    rst = 1'b1;
    cfg = 4'h0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    osc_ready = 1'b0;
    pll_locked = 1'b0;
    clock_fail = 1'b0;
    pwm_phase = 3'h0;
    errors = 0;
    tests_run = 0;
    cycles = 0;
    do_reset(4'h0);
    t_reset();
    t_switch();
    t_pll();
    t_fail();
    t_bits();
    t_trim();
    t_lock();
    stop_test();
  end
endmodule : osc_switch_tune_ctrl_test
bind osc_switch_tune_ctrl osc_ctrl_chk chk (.sys_clk(sys_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .cfg(cfg), .osc_ready(osc_ready), .pll_locked(pll_locked),
  .clock_fail(clock_fail), .pwm_phase(pwm_phase),
  .active_clock_group(active_clock_group), .switch_target(switch_target),
  .switch_busy(switch_busy), .clock_dither_enable(clock_dither_enable),
  .rc_trim(rc_trim));
`default_nettype wire
